// *** core/bawd_pkg.sv ***
// Constants, field layouts and carrier types for the bridge window decoder.
// Assumes a single 50 MHz clock and an AHB-Lite register master.
//
// Function
// - Forward downstream memory inside non-prefetchable window.
// - Upstream memory outside both windows goes up.
// - Memory disabled: downstream UR, all upstream.
// - Master disabled: upstream memory ignored.
// - Non-prefetchable window is 1 MB granular.
// - Prefetchable window 1 MB, 64-bit base/limit.
// - Prefetchable base above limit disables window.
// - Prefetchable hits go down, not up, while memory is enabled.
// - Short addresses below 4 GB, long above.
// - Non-prefetchable upstream prefetch only line/multiple.
// - Prefetchable upstream prefetch for all reads.
// - I/O window 32-bit from upper 16 extensions.
// - I/O window is 4 KB granular.
// - I/O disabled: downstream UR, all upstream.
// - Master disabled: upstream I/O ignored.
// - Alias mode blocks upper 768 bytes downstream.
// - Alias mode sends upper 768 bytes upstream.
// - I/O above 64 KB decided by window only.
// - I/O inside window down, outside up.
`default_nettype none

package bawd_pkg;

  // Register byte offsets.
  localparam logic [7:0] BAWD_CTRL_OFS     = 8'h00;
  localparam logic [7:0] BAWD_MEM_OFS      = 8'h04;
  localparam logic [7:0] BAWD_PF_OFS       = 8'h08;
  localparam logic [7:0] BAWD_PF_BASEU_OFS = 8'h0C;
  localparam logic [7:0] BAWD_PF_LIMU_OFS  = 8'h10;
  localparam logic [7:0] BAWD_IO_OFS       = 8'h14;
  localparam logic [7:0] BAWD_IO_UPR_OFS   = 8'h18;
  localparam logic [7:0] BAWD_STAT_OFS     = 8'h1C;

  // Control register field positions.
  localparam int BAWD_IO_EN_BIT    = 0;
  localparam int BAWD_MEM_EN_BIT   = 1;
  localparam int BAWD_MST_EN_BIT   = 2;
  localparam int BAWD_ALIAS_EN_BIT = 3;

  // Memory window register fields: base in [15:4], limit in [31:20].
  localparam int BAWD_BASE_LSB = 4;
  localparam int BAWD_LIM_LSB  = 20;
  localparam int BAWD_MEM_GRAN = 20;
  localparam int BAWD_IO_GRAN  = 12;

  // Reset values.
  localparam logic [31:0] BAWD_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] BAWD_WIN_RST  = 32'h0000_0000;

  // Legacy alias region: below 64 KB, offsets 100h..3FFh of each 1 KB.
  localparam logic [15:0] BAWD_IO_ALIAS_TOP = 16'hFFFF;

  // Upstream memory read and write commands.
  typedef enum logic [1:0] {
    BAWD_MEM_RD  = 2'h0,
    BAWD_MEM_RDL = 2'h1,
    BAWD_MEM_RDM = 2'h2,
    BAWD_MEM_WR  = 2'h3
  } bawd_cmd_t;

  // Downstream (link side) request.
  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic        long_addr;
    logic [63:0] addr;
  } bawd_dn_req_t;

  // Upstream (bus side) request.
  typedef struct packed {
    logic        valid;
    logic        is_io;
    bawd_cmd_t   cmd;
    logic [63:0] addr;
  } bawd_up_req_t;

  // Downstream decision.
  typedef struct packed {
    logic valid;
    logic forward;
    logic unsupported;
    logic block;
  } bawd_dn_res_t;

  // Upstream decision.
  typedef struct packed {
    logic valid;
    logic forward;
    logic ignore;
    logic prefetch;
  } bawd_up_res_t;

endpackage : bawd_pkg

`default_nettype wire

// *** core/bawd_top.sv ***
// Address window decoder of a link-to-bus bridge with AHB-Lite registers.
// Assumes one master, whole-word single transfers, synchronous inputs.
//
// Design decisions made here: register access over AHB-Lite and the register offsets.
`default_nettype none

module bawd_top (
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  input  wire logic                   hsel_i,
  input  wire logic [31:0]            haddr_i,
  input  wire logic [1:0]             htrans_i,
  input  wire logic                   hwrite_i,
  input  wire logic [2:0]             hsize_i,
  input  wire logic [31:0]            hwdata_i,
  input  wire logic                   hready_i,
  output logic      [31:0]            hrdata_o,
  output logic                        hreadyout_o,
  output logic                        hresp_o,
  input  wire bawd_pkg::bawd_dn_req_t dn_req_i,
  output bawd_pkg::bawd_dn_res_t      dn_res_o,
  input  wire bawd_pkg::bawd_up_req_t up_req_i,
  output bawd_pkg::bawd_up_res_t      up_res_o
);
  import bawd_pkg::*;

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] mem_win;
  logic [31:0] pf_win;
  logic [31:0] pf_base_up;
  logic [31:0] pf_lim_up;
  logic [31:0] io_win;
  logic [31:0] io_up;
  logic [31:0] status;
  logic        wr_pend;
  logic [7:0]  wr_ofs;

  // Address phase is taken when selected, NONSEQ/SEQ and ready.
  wire addr_take = hsel_i && htrans_i[1] && hready_i;
  wire [7:0] a_ofs = haddr_i[7:0];

  // Address phase capture for writes.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_pend <= 1'b0;
      wr_ofs  <= 8'h00;
    end else begin
      wr_pend <= addr_take && hwrite_i;
      wr_ofs  <= a_ofs;
    end
  end

  // Write data lands in the data phase; unmapped offsets are dropped.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl       <= BAWD_CTRL_RST;
      mem_win    <= BAWD_WIN_RST;
      pf_win     <= BAWD_WIN_RST;
      pf_base_up <= BAWD_WIN_RST;
      pf_lim_up  <= BAWD_WIN_RST;
      io_win     <= BAWD_WIN_RST;
      io_up      <= BAWD_WIN_RST;
    end else if (wr_pend) begin
      case (wr_ofs)
        BAWD_CTRL_OFS:     ctrl       <= hwdata_i;
        BAWD_MEM_OFS:      mem_win    <= hwdata_i;
        BAWD_PF_OFS:       pf_win     <= hwdata_i;
        BAWD_PF_BASEU_OFS: pf_base_up <= hwdata_i;
        BAWD_PF_LIMU_OFS:  pf_lim_up  <= hwdata_i;
        BAWD_IO_OFS:       io_win     <= hwdata_i;
        BAWD_IO_UPR_OFS:   io_up      <= hwdata_i;
        default:           ctrl       <= ctrl;
      endcase
    end
  end

  // Read mux; reserved control bits and unmapped offsets read zero.
  logic [31:0] rd_val;
  always_comb begin
    case (a_ofs)
      BAWD_CTRL_OFS:     rd_val = {28'h0000000, ctrl[3:0]};
      BAWD_MEM_OFS:      rd_val = mem_win;
      BAWD_PF_OFS:       rd_val = pf_win;
      BAWD_PF_BASEU_OFS: rd_val = pf_base_up;
      BAWD_PF_LIMU_OFS:  rd_val = pf_lim_up;
      BAWD_IO_OFS:       rd_val = io_win;
      BAWD_IO_UPR_OFS:   rd_val = io_up;
      BAWD_STAT_OFS:     rd_val = status;
      default:           rd_val = 32'h0000_0000;
    endcase
  end

  // Zero wait states, always OKAY.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (addr_take && !hwrite_i) begin
        hrdata_o <= rd_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // Window bounds
  // ----------------------------------------------------------------
  wire io_en    = ctrl[BAWD_IO_EN_BIT];
  wire mem_en   = ctrl[BAWD_MEM_EN_BIT];
  wire mst_en   = ctrl[BAWD_MST_EN_BIT];
  wire alias_en = ctrl[BAWD_ALIAS_EN_BIT];

  // Memory window: 1 MB aligned base, limit fills its last megabyte.
  wire [31:0] mem_base = {mem_win[15:4], 20'h00000};
  wire [31:0] mem_lim  = {mem_win[31:20], 20'hFFFFF};
  wire        mem_on   = mem_base <= mem_lim;

  // Prefetchable window built from 64-bit base and limit.
  wire [63:0] pf_base = {pf_base_up, pf_win[15:4], 20'h00000};
  wire [63:0] pf_lim  = {pf_lim_up, pf_win[31:20], 20'hFFFFF};
  wire        pf_on   = pf_base <= pf_lim;

  // I/O window: 4 KB aligned, upper halves from the extension word.
  wire [31:0] io_base = {io_up[15:0], io_win[7:4], 12'h000};
  wire [31:0] io_lim  = {io_up[31:16], io_win[15:12], 12'hFFF};
  wire        io_on   = io_base <= io_lim;

  // ----------------------------------------------------------------
  // Downstream decode
  // ----------------------------------------------------------------
  wire [63:0] d_a   = dn_req_i.addr;
  wire        d_hi  = |d_a[63:32];
  // Short requests carry no address bits above 4 GB, so a short memory request
  // with any upper bit set is never claimed. Long requests go on to the
  // window compare, which only lets them reach the part at or above 4 GB.
  wire        d_lo  = dn_req_i.long_addr || !d_hi;
  wire d_in_mem = mem_on && !d_hi && !dn_req_i.long_addr
                  && d_a[31:0] >= mem_base && d_a[31:0] <= mem_lim;
  wire d_in_pf  = pf_on && d_a >= pf_base && d_a <= pf_lim
                  && (dn_req_i.long_addr ? d_hi : 1'b1);
  wire d_in_io  = io_on && d_a[31:0] >= io_base
                  && d_a[31:0] <= io_lim;
  // Alias block: below 64 KB with offset bits 9:8 not both zero.
  wire d_alias  = alias_en && d_a[31:16] == 16'h0000
                  && |d_a[9:8];
  wire d_mem_go = mem_en && (d_in_mem || d_in_pf) && d_lo;
  wire d_io_go  = io_en && d_in_io && !d_alias;
  wire d_ur     = dn_req_i.is_io ? !io_en : !mem_en;
  wire d_go     = dn_req_i.is_io ? d_io_go : d_mem_go;

  // Downstream answer, one cycle after the request.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dn_res_o <= '0;
    end else begin
      dn_res_o.valid       <= dn_req_i.valid;
      dn_res_o.forward     <= dn_req_i.valid && d_go;
      dn_res_o.unsupported <= dn_req_i.valid && d_ur;
      dn_res_o.block       <= dn_req_i.valid && !d_go && !d_ur;
    end
  end

  // ----------------------------------------------------------------
  // Upstream decode
  // ----------------------------------------------------------------
  wire [63:0] u_a   = up_req_i.addr;
  wire u_in_mem = mem_on && u_a[63:32] == 32'h0000_0000
                  && u_a[31:0] >= mem_base && u_a[31:0] <= mem_lim;
  wire u_in_pf  = pf_on && u_a >= pf_base && u_a <= pf_lim;
  // Claimed windows count only while memory decoding is enabled.
  wire u_mem_go = !mem_en || !(u_in_mem || u_in_pf);
  wire u_in_io  = io_on && u_a[31:0] >= io_base
                  && u_a[31:0] <= io_lim;
  wire u_alias  = alias_en && u_a[31:16] == 16'h0000
                  && |u_a[9:8];
  wire u_io_go  = !io_en || !u_in_io || u_alias;
  wire u_go     = mst_en && (up_req_i.is_io ? u_io_go : u_mem_go);
  wire u_read   = up_req_i.cmd != BAWD_MEM_WR;
  // Prefetchable space is a property of the address range, so a read
  // that lands in it may prefetch even when memory decoding is off.
  wire u_pf_rd  = u_in_pf;
  wire u_pref   = !up_req_i.is_io && u_read &&
                  (u_pf_rd || up_req_i.cmd != BAWD_MEM_RD);

  // Upstream answer, one cycle after the request.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      up_res_o <= '0;
    end else begin
      up_res_o.valid    <= up_req_i.valid;
      up_res_o.forward  <= up_req_i.valid && u_go;
      up_res_o.ignore   <= up_req_i.valid && !mst_en;
      up_res_o.prefetch <= up_req_i.valid && u_go && u_pref;
    end
  end

  // Status word shows which windows are open.
  assign status = {29'h00000000, io_on, pf_on, mem_on};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  ur_mem_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    dn_req_i.valid && !dn_req_i.is_io && !mem_en |=>
      dn_res_o.unsupported && !dn_res_o.forward)
    else $error("memory request not refused while disabled");
  ur_io_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    dn_req_i.valid && dn_req_i.is_io && !io_en |=>
      dn_res_o.unsupported && !dn_res_o.forward)
    else $error("io request not refused while disabled");
  mst_off_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    up_req_i.valid && !mst_en |=> up_res_o.ignore && !up_res_o.forward)
    else $error("upstream forwarded with master off");
  up_mem_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    up_req_i.valid && !up_req_i.is_io && mst_en && !mem_en
      |=> up_res_o.forward)
    else $error("upstream memory not forwarded");
  pf_down_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    dn_req_i.valid && !dn_req_i.is_io && mem_en && pf_on
      && dn_req_i.long_addr && d_hi && d_a >= pf_base && d_a <= pf_lim
      |=> dn_res_o.forward)
    else $error("prefetchable hit not forwarded");
  alias_blk_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    dn_req_i.valid && dn_req_i.is_io && alias_en
      && d_a[31:16] == 16'h0000 && d_a[9:8] != 2'b00 |=> !dn_res_o.forward)
    else $error("alias io passed downstream");
  alias_up_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    up_req_i.valid && up_req_i.is_io && mst_en && alias_en
      && u_a[31:16] == 16'h0000 && u_a[9:8] != 2'b00 |=> up_res_o.forward)
    else $error("alias io not sent upstream");
  np_pref_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    up_req_i.valid && up_req_i.cmd == BAWD_MEM_RD && !u_pf_rd
      |=> !up_res_o.prefetch)
    else $error("plain read prefetched outside window");
  pf_off_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    dn_req_i.valid && !dn_req_i.is_io && dn_req_i.long_addr && !pf_on
      |=> !dn_res_o.forward)
    else $error("long request forwarded with prefetch window off");

  // Window hits and misses on both sides, one cycle after the request.
  mem_fwd_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    dn_req_i.valid && !dn_req_i.is_io && mem_en && !dn_req_i.long_addr
      && !d_hi && mem_on && d_a[31:0] >= mem_base && d_a[31:0] <= mem_lim
      |=> dn_res_o.forward)
    else $error("memory window hit not forwarded");
  up_np_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    up_req_i.valid && !up_req_i.is_io && mem_en && u_in_mem
      |=> !up_res_o.forward)
    else $error("memory window hit sent upstream");
  short_hi_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    dn_req_i.valid && !dn_req_i.is_io && !dn_req_i.long_addr && d_hi
      |=> !dn_res_o.forward)
    else $error("short request above 4 GB forwarded");
  pf_pref_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    up_req_i.valid && !up_req_i.is_io && mst_en && !mem_en && u_in_pf
      && up_req_i.cmd != BAWD_MEM_WR |=> up_res_o.prefetch)
    else $error("prefetchable read not prefetched");
  mst_io_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    up_req_i.valid && up_req_i.is_io && !mst_en
      |=> up_res_o.ignore && !up_res_o.forward)
    else $error("upstream io forwarded with master off");
  io_fwd_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    dn_req_i.valid && dn_req_i.is_io && io_en && d_in_io && !alias_en
      |=> dn_res_o.forward)
    else $error("io window hit not forwarded");
  up_io_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    up_req_i.valid && up_req_i.is_io && mst_en && io_en && u_in_io
      && !u_alias |=> !up_res_o.forward)
    else $error("io window hit sent upstream");
  io_hi_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    dn_req_i.valid && dn_req_i.is_io && io_en && alias_en
      && d_a[31:16] != 16'h0000 && d_in_io |=> dn_res_o.forward)
    else $error("io above 64 KB not decided by window");

endmodule : bawd_top

`default_nettype wire

// *** verif/bawd_far_model.sv ***
// Far-side request source: link requester and bus-side agents.
// Assumes the bench calls send just after a rising edge of clk_i.
`default_nettype none

module bawd_far_model (
  input  wire logic             clk_i,
  output var bawd_pkg::bawd_dn_req_t dn_req_o,
  output var bawd_pkg::bawd_up_req_t up_req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import bawd_pkg::*;

  // Both sides start idle.
  initial begin
    dn_req_o = '0;
    up_req_o = '0;
  end

  // One request for one edge; the dropped address is inverted so a stale
  // value never passes for a live one.
  task automatic send(input logic up, input logic io, input logic lng,
                      input bawd_cmd_t cmd, input logic [63:0] a);
    @(posedge clk_i);
    if (up) begin
      up_req_o <= '{1'h1, io, cmd, a};
    end else begin
      dn_req_o <= '{1'h1, io, lng, a};
    end
    @(posedge clk_i);
    up_req_o <= '{1'h0, 1'h0, BAWD_MEM_RD, ~a};
    dn_req_o <= '{1'h0, 1'h0, 1'h0, ~a};
  endtask : send

endmodule : bawd_far_model

`default_nettype wire

// *** verif/test_bridge_address_window_decode.sv ***
// Self-checking bench for the bridge window decoder.
// Assumes bawd_top and bawd_far_model; registers reached over AHB-Lite.
`default_nettype none

module test_bridge_address_window_decode;
  timeunit 1ns;
  timeprecision 1ns;
  import bawd_pkg::*;

  typedef struct packed {
    logic        up;
    logic        io;
    logic        lng;
    bawd_cmd_t   cmd;
    logic [63:0] a;
    logic [3:0]  exp;
  } bawd_tb_row_t;

  localparam logic DN = 1'h0;
  localparam logic UP = 1'h1;
  localparam logic MM = 1'h0;
  localparam logic IO = 1'h1;
  localparam logic SH = 1'h0;
  localparam logic LG = 1'h1;

  logic         clk_i    = 1'h0;
  logic         rstn_i   = 1'h0;
  logic         hsel_i   = 1'h0;
  logic [31:0]  haddr_i  = 32'h0;
  logic [1:0]   htrans_i = 2'h0;
  logic         hwrite_i = 1'h0;
  logic [2:0]   hsize_i  = 3'h2;
  logic [31:0]  hwdata_i = 32'h0;
  logic [31:0]  hrdata_o;
  logic         hreadyout_o;
  logic         hresp_o;
  bawd_dn_req_t dn_req_i;
  bawd_up_req_t up_req_i;
  bawd_dn_res_t dn_res_o;
  bawd_up_res_t up_res_o;
  logic [31:0]  rd;
  int           n_errors    = 0;
  int           check_count = 0;

  // ----------------------------------------------------------------------
  // Ordinary cases under memory, I/O and master enables, alias off.
  // ----------------------------------------------------------------------
  bawd_tb_row_t rows [$] = '{
    '{DN, MM, SH, BAWD_MEM_RD,  64'h0FFF_FFFF,   4'h9},
    '{DN, MM, SH, BAWD_MEM_RD,  64'h1000_0000,   4'hC},
    '{DN, MM, SH, BAWD_MEM_RD,  64'h1FFF_FFFF,   4'hC},
    '{DN, MM, SH, BAWD_MEM_RD,  64'h2000_0000,   4'h9},
    '{DN, MM, SH, BAWD_MEM_RD,  64'hF000_0000,   4'hC},
    '{DN, MM, LG, BAWD_MEM_RD,  64'h1_00FF_FFFF, 4'hC},
    '{DN, MM, LG, BAWD_MEM_RD,  64'h1_0100_0000, 4'h9},
    '{DN, MM, LG, BAWD_MEM_RD,  64'hF000_0000,   4'h9},
    '{DN, IO, SH, BAWD_MEM_RD,  64'h1FFF,        4'h9},
    '{DN, IO, SH, BAWD_MEM_RD,  64'h2000,        4'hC},
    '{DN, IO, SH, BAWD_MEM_RD,  64'h3FFF,        4'hC},
    '{DN, IO, SH, BAWD_MEM_RD,  64'h4000,        4'h9},
    '{UP, MM, SH, BAWD_MEM_RD,  64'h1800_0000,   4'h8},
    '{UP, MM, SH, BAWD_MEM_RDL, 64'h0800_0000,   4'hD},
    '{UP, MM, SH, BAWD_MEM_RD,  64'h0800_0000,   4'hC},
    '{UP, MM, SH, BAWD_MEM_WR,  64'h0800_0000,   4'hC},
    '{UP, MM, SH, BAWD_MEM_RDM, 64'h1_0000_0000, 4'h8},
    '{UP, MM, SH, BAWD_MEM_RDM, 64'h1_0100_0000, 4'hD},
    '{UP, IO, SH, BAWD_MEM_WR,  64'h2000,        4'h8},
    '{UP, IO, SH, BAWD_MEM_WR,  64'h4000,        4'hC}
  };

  // Free-running 50 MHz clock.
  always #10 clk_i = ~clk_i;

  bawd_top bawd_top_i (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hsize_i     (hsize_i),
    .hwdata_i    (hwdata_i),
    .hready_i    (hreadyout_o),
    .hrdata_o    (hrdata_o),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o),
    .dn_req_i    (dn_req_i),
    .dn_res_o    (dn_res_o),
    .up_req_i    (up_req_i),
    .up_res_o    (up_res_o)
  );

  bawd_far_model bawd_far_model_i (
    .clk_i    (clk_i),
    .dn_req_o (dn_req_i),
    .up_req_o (up_req_i)
  );

  task automatic give_verdict();
    if (n_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  task automatic cmp32(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp32

  // One single AHB-Lite word transfer; entered just after a rising edge.
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel_i   <= 1'h1;
    htrans_i <= 2'h2;
    haddr_i  <= {24'h0, a};
    hwrite_i <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'h1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'h1);
    rd = hrdata_o;
  endtask : ahb

  task automatic chk(input logic up, input logic io, input logic lng,
                     input bawd_cmd_t cmd, input logic [63:0] a,
                     input logic [3:0] exp);
    logic [3:0] got;
    bawd_far_model_i.send(up, io, lng, cmd, a);
    #1;
    got = up ? 4'(up_res_o) : 4'(dn_res_o);
    cmp32(up ? "up_res" : "dn_res", {28'h0, exp}, {28'h0, got});
  endtask : chk

  // Cuts a hang short well past the expected run length.
  initial begin
    #40000;
    n_errors++;
    give_verdict();
  end

  // Main sequence: reset, registers, rows, then the awkward cases.
  initial begin
    repeat (5) @(posedge clk_i);
    cmp32("rst_out", 32'h200,
          {22'h0, hreadyout_o, hresp_o, dn_res_o, up_res_o});
    rstn_i <= 1'h1;
    @(posedge clk_i);
    ahb(1'h0, BAWD_CTRL_OFS, 32'h0);
    cmp32("ctrl_rst", BAWD_CTRL_RST, rd);
    ahb(1'h1, 8'h20, 32'hFFFF_FFFF);
    ahb(1'h0, 8'h20, 32'h0);
    cmp32("unmapped", 32'h0, rd);
    ahb(1'h1, BAWD_MEM_OFS, 32'h1FF0_1000);
    ahb(1'h1, BAWD_PF_OFS, 32'h00F0_F000);
    ahb(1'h1, BAWD_PF_LIMU_OFS, 32'h1);
    ahb(1'h1, BAWD_IO_OFS, 32'h3020);
    ahb(1'h1, BAWD_CTRL_OFS, 32'h7);
    ahb(1'h0, BAWD_MEM_OFS, 32'h0);
    cmp32("mem_win", 32'h1FF0_1000, rd);
    ahb(1'h0, BAWD_STAT_OFS, 32'h0);
    cmp32("status", 32'h7, rd);
    foreach (rows[i]) begin
      chk(rows[i].up, rows[i].io, rows[i].lng, rows[i].cmd, rows[i].a,
          rows[i].exp);
    end
    chk(DN, MM, SH, BAWD_MEM_RD, 64'h1_0000_0080, 4'h9);
    ahb(1'h1, BAWD_PF_BASEU_OFS, 32'h2);
    ahb(1'h0, BAWD_STAT_OFS, 32'h0);
    cmp32("status_pf_off", 32'h5, rd);
    chk(DN, MM, LG, BAWD_MEM_RD, 64'h1_0000_0000, 4'h9);
    chk(UP, MM, SH, BAWD_MEM_RD, 64'h1_0000_0000, 4'hC);
    chk(DN, MM, SH, BAWD_MEM_RD, 64'h1000_0000, 4'hC);
    ahb(1'h1, BAWD_PF_BASEU_OFS, 32'h0);
    ahb(1'h1, BAWD_CTRL_OFS, 32'h5);
    chk(DN, MM, SH, BAWD_MEM_RD, 64'h1000_0000, 4'hA);
    chk(UP, MM, SH, BAWD_MEM_RD, 64'h1_0000_0000, 4'hD);
    chk(UP, MM, SH, BAWD_MEM_RD, 64'h1800_0000, 4'hC);
    ahb(1'h1, BAWD_CTRL_OFS, 32'h6);
    chk(DN, IO, SH, BAWD_MEM_RD, 64'h2000, 4'hA);
    chk(UP, IO, SH, BAWD_MEM_WR, 64'h2000, 4'hC);
    ahb(1'h1, BAWD_CTRL_OFS, 32'h3);
    chk(UP, MM, SH, BAWD_MEM_RDL, 64'h0800_0000, 4'hA);
    chk(UP, IO, SH, BAWD_MEM_WR, 64'h4000, 4'hA);
    ahb(1'h1, BAWD_CTRL_OFS, 32'hF);
    chk(DN, IO, SH, BAWD_MEM_RD, 64'h2100, 4'h9);
    chk(DN, IO, SH, BAWD_MEM_RD, 64'h23FF, 4'h9);
    chk(DN, IO, SH, BAWD_MEM_RD, 64'h2000, 4'hC);
    chk(UP, IO, SH, BAWD_MEM_WR, 64'h2100, 4'hC);
    chk(UP, IO, SH, BAWD_MEM_WR, 64'h2400, 4'h8);
    ahb(1'h1, BAWD_IO_UPR_OFS, 32'h0001_0001);
    chk(DN, IO, SH, BAWD_MEM_RD, 64'h1_2100, 4'hC);
    chk(DN, IO, SH, BAWD_MEM_RD, 64'h2000, 4'h9);
    chk(UP, IO, SH, BAWD_MEM_WR, 64'h1_2100, 4'h8);
    // A reset in mid-run must clear outputs and the control and I/O extension registers.
    rstn_i <= 1'h0;
    @(posedge clk_i);
    cmp32("rst_mid", 32'h200,
          {22'h0, hreadyout_o, hresp_o, dn_res_o, up_res_o});
    rstn_i <= 1'h1;
    @(posedge clk_i);
    ahb(1'h0, BAWD_CTRL_OFS, 32'h0);
    cmp32("ctrl_mid", BAWD_CTRL_RST, rd);
    ahb(1'h0, BAWD_IO_UPR_OFS, 32'h0);
    cmp32("io_up_mid", BAWD_WIN_RST, rd);
    give_verdict();
  end

endmodule : test_bridge_address_window_decode

`default_nettype wire
